// File: verilog/charger_event_flag_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "flag_bank_defs.vh"

// Behaviour
// R01: Port detect result change sets bit 0
// R02: Data-line done flag zero until detection finishes
// R03: Conversion done flag only in one-shot mode
// R04: Min-system flag on loop entry and exit
// R05: Fast-charge timer expiry rising edge sets flag
// R06: Trickle timer expiry rising edge sets flag
// R07: Pre-charge timer expiry rising edge sets flag
// R08: Top-off timer expiry rising edge sets flag
// R09: Battery too low for OTG sets flag
// R10: Crossing cold threshold sets cold flag
// R11: Crossing cool threshold sets cool flag
// R12: Crossing warm threshold sets warm flag
// R13: Crossing hot threshold sets hot flag
// R14: Battery current regulation entry or exit flags
// R15: Bus over-voltage entry sets flag
// R16: Battery over-voltage entry sets flag
// R17: Bus over-current entry sets flag
// R18: Battery discharge over-current entry sets flag
// R19: Converter over-current entry sets flag
// R20: Flags read-only, zero at reset, reserved zero
// R21: Interrupt pulse only when mask bit zero
// R22: Reading a register clears its flags
module charger_event_flag_bank (
   // Clock and reset
   input  wire                      ref_clk,
   input  wire                      rst,
   // Register read port from the serial interface logic
   input  wire                      rd_en,
   input  wire [7:0]                rd_addr,
   output reg  [7:0]                rd_data_q,
   output reg                       rd_valid_q,
   // Mask registers kept by the interrupt section
   input  wire [7:0]                chg_mask_1,
   input  wire [7:0]                chg_mask_2,
   input  wire [7:0]                chg_mask_3,
   input  wire [7:0]                fault_mask_0,
   // Port detection and data-line detection
   input  wire [`PORT_DETECT_W-1:0] port_detect_result,
   input  wire                      data_line_detect_done,
   // Converter status
   input  wire                      adc_conv_done,
   input  wire                      adc_one_shot,
   // Regulation loops
   input  wire                      min_system_reg_active,
   input  wire                      battery_current_reg_active,
   // Safety timer expiry levels: fast, trickle, pre-charge, top-off
   input  wire [3:0]                timer_expired,
   // Battery and thermistor comparators: cold, cool, warm, hot
   input  wire                      battery_low_for_otg,
   input  wire [3:0]                thermistor_zone,
   // Protection levels: bus OVP, batt OVP, bus OCP, batt OCP, conv OCP
   input  wire [4:0]                protection_active,
   // Interrupt pulse toward the interrupt pin driver
   output reg                       int_pulse_q,
   // Flag registers for observation
   output reg  [7:0]                charger_event_flags_1_q,
   output reg  [7:0]                charger_event_flags_2_q,
   output reg  [7:0]                charger_event_flags_3_q,
   output reg  [7:0]                fault_event_flags_0_q
);

   // The synchroniser carries one lane per status bit; the bundle order
   // below fixes which lane feeds which flag
   // Number of asynchronous status bits entering the synchroniser
   localparam SYNC_W = 23;

   wire [SYNC_W-1:0] sync_raw;    // Raw status bundle
   wire [SYNC_W-1:0] sync_level;  // Synchronised levels
   wire [SYNC_W-1:0] sync_rise;   // Rising edges
   wire [SYNC_W-1:0] sync_fall;   // Falling edges

   // Every status below is a level from the analog or sequencing side and
   // may change at any time; none of it is read before two flops have
   // settled it. The mask inputs and the read port come from logic on
   // this clock and are used directly.
   // Bundle every analog status so one synchroniser serves them all
   assign sync_raw = {protection_active,           // 22:18
                      battery_current_reg_active,  // 17
                      thermistor_zone,             // 16:13
                      battery_low_for_otg,         // 12
                      timer_expired,               // 11:8
                      min_system_reg_active,       // 7
                      adc_one_shot,                // 6
                      adc_conv_done,               // 5
                      data_line_detect_done,       // 4
                      port_detect_result};         // 3:0

   // Edges are taken after the second stage, so a level that glitches for
   // less than a cycle may be missed; status levels must stand two cycles
   // Two-flop synchroniser and edge detector
   edge_sync #(
      .W (SYNC_W)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (sync_raw),
      .level    (sync_level),
      .rise     (sync_rise),
      .fall     (sync_fall)
   );

   reg [`PORT_DETECT_W-1:0] port_code_prev_q;   // Synchronised code one cycle ago
   reg [`PORT_DETECT_W-1:0] port_code_seen_q;   // Last code taken as settled
   wire                     port_code_steady;   // Code held still for a cycle
   wire                     port_code_change;   // Settled code differs from the last one

   // The code bits cross one by one, so a single change may land over two
   // cycles; the code is only taken once it held still for a cycle, which
   // keeps one change of the result to one event and one pulse
   assign port_code_steady = (sync_level[`PORT_DETECT_W-1:0] == port_code_prev_q);
   assign port_code_change = port_code_steady
                           & (sync_level[`PORT_DETECT_W-1:0] != port_code_seen_q);

   // Track the code and the last settled value
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // Power-on code matches the reset state of the synchroniser
         port_code_prev_q <= `PORT_CODE_RESET;
         port_code_seen_q <= `PORT_CODE_RESET;
      end else begin
         port_code_prev_q <= sync_level[`PORT_DETECT_W-1:0];
         // Take the code only when it has settled
         if (port_code_steady) begin
            port_code_seen_q <= sync_level[`PORT_DETECT_W-1:0];                // [R01]
         end
      end
   end

   // Set requests, one vector per register
   reg [7:0] set_1;   // Events for the first charger flag register
   reg [7:0] set_2;   // Events for the second charger flag register
   reg [7:0] set_3;   // Events for the third charger flag register
   reg [7:0] set_0;   // Events for the first fault flag register

   // Each flag has its own sense of event: some fire on entry only, some on
   // entry and exit, and the thermistor flags on any crossing of their
   // threshold in either direction
   // Translate synchronised edges into flag set requests
   always @* begin
      set_1 = 8'h00;
      set_2 = 8'h00;
      set_3 = 8'h00;
      set_0 = 8'h00;
      // A settled change of the detection result code
      set_1[`PORT_DETECT_CHANGE_BIT] = port_code_change;                        // [R01]
      // Detection has just finished
      set_2[`DATA_LINE_DONE_BIT]     = sync_rise[4];                          // [R02]
      // Completion counts only in one-shot mode
      set_2[`ADC_DONE_BIT]           = sync_rise[5] & sync_level[6];          // [R03]
      // Both entry and exit of the minimum system loop
      set_2[`MIN_SYSTEM_REG_BIT]     = sync_rise[7] | sync_fall[7];           // [R04]
      // Timer expiry rising edges
      set_2[`FAST_CHARGE_TMR_BIT]    = sync_rise[11];                         // [R05]
      set_2[`TRICKLE_TMR_BIT]        = sync_rise[10];                         // [R06]
      set_2[`PRECHARGE_TMR_BIT]      = sync_rise[9];                          // [R07]
      set_2[`TOPOFF_TMR_BIT]         = sync_rise[8];                          // [R08]
      // Battery falls below the OTG enable threshold
      set_3[`BATT_LOW_OTG_BIT]       = sync_rise[12];                         // [R09]
      // Thermistor crossing in either direction
      set_3[`THERM_COLD_BIT]         = sync_rise[16] | sync_fall[16];         // [R10]
      set_3[`THERM_COOL_BIT]         = sync_rise[15] | sync_fall[15];         // [R11]
      set_3[`THERM_WARM_BIT]         = sync_rise[14] | sync_fall[14];         // [R12]
      set_3[`THERM_HOT_BIT]          = sync_rise[13] | sync_fall[13];         // [R13]
      // Battery current loop entry or exit
      set_0[`BATT_CURRENT_REG_BIT]   = sync_rise[17] | sync_fall[17];         // [R14]
      // Protection entries
      set_0[`BUS_OVP_BIT]            = sync_rise[22];                         // [R15]
      set_0[`BATT_OVP_BIT]           = sync_rise[21];                         // [R16]
      set_0[`INPUT_OCP_BIT]          = sync_rise[20];                         // [R17]
      set_0[`BATT_OCP_BIT]           = sync_rise[19];                         // [R18]
      set_0[`CONV_OCP_BIT]           = sync_rise[18];                         // [R19]
   end

   // An address outside the four flag registers decodes to nothing, so
   // such a read has no side effect and returns zero
   wire hit_1;   // Read of the first charger flag register
   wire hit_2;   // Read of the second charger flag register
   wire hit_3;   // Read of the third charger flag register
   wire hit_0;   // Read of the first fault flag register

   // Address decode of the read port
   assign hit_1 = rd_en & (rd_addr == `CHG_FLAGS_1_OFFSET);
   assign hit_2 = rd_en & (rd_addr == `CHG_FLAGS_2_OFFSET);
   assign hit_3 = rd_en & (rd_addr == `CHG_FLAGS_3_OFFSET);
   assign hit_0 = rd_en & (rd_addr == `FAULT_FLAGS_0_OFFSET);

   reg [7:0] clr_2;   // Clear mask of the second charger flag register

   // The data-line done flag is a status of the detector as much as an
   // event: it must read zero whenever the detector is idle or busy, so
   // the low level clears it as a read would
   // Read clears all; a detector that is idle or running also holds done low
   always @* begin
      clr_2 = {8{hit_2}};                                                       // [R22]
      clr_2[`DATA_LINE_DONE_BIT] = hit_2 | ~sync_level[4];                      // [R02]
   end

   // A flag that is set in the same cycle as its register is read stays
   // set, so an event can never fall between a read and its clear; the
   // host simply sees it again on the next read
   // Next flag value: set wins over a clear in the same cycle
   function [7:0] flag_next;
      input [7:0] cur;
      input [7:0] set;
      input [7:0] clr;
      input [7:0] used;
      begin
         flag_next = ((cur & ~clr) | set) & used;                               // [R20]
      end
   endfunction

   // One next-state value per flag register
   wire [7:0] flags_1_d;   // Next first charger flags
   wire [7:0] flags_2_d;   // Next second charger flags
   wire [7:0] flags_3_d;   // Next third charger flags
   wire [7:0] flags_0_d;   // Next first fault flags

   assign flags_1_d = flag_next(charger_event_flags_1_q, set_1, {8{hit_1}},
                                `CHG_FLAGS_1_USED);                             // [R22]
   assign flags_2_d = flag_next(charger_event_flags_2_q, set_2, clr_2,
                                `CHG_FLAGS_2_USED);
   assign flags_3_d = flag_next(charger_event_flags_3_q, set_3, {8{hit_3}},
                                `CHG_FLAGS_3_USED);                             // [R22]
   assign flags_0_d = flag_next(fault_event_flags_0_q, set_0, {8{hit_0}},
                                `FAULT_FLAGS_0_USED);                           // [R22]

   // Only events set bits, and only reads, the done level or the reset
   // clear them
   // Flag storage; the host has no write path into it
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         charger_event_flags_1_q <= `FLAGS_RESET;                               // [R20]
         charger_event_flags_2_q <= `FLAGS_RESET;
         charger_event_flags_3_q <= `FLAGS_RESET;
         fault_event_flags_0_q   <= `FLAGS_RESET;
      end else begin
         charger_event_flags_1_q <= flags_1_d;
         charger_event_flags_2_q <= flags_2_d;
         charger_event_flags_3_q <= flags_3_d;
         fault_event_flags_0_q   <= flags_0_d;
      end
   end

   reg [7:0] rd_mux;   // Read data selected by address

   // The answer is taken from the flags as they stand when the request is
   // taken, so the clear on the same edge cannot hide an event
   // Return the value held before the clearing edge; unmapped reads zero
   always @* begin
      case (1'b1)
         hit_1:   rd_mux = charger_event_flags_1_q;
         hit_2:   rd_mux = charger_event_flags_2_q;
         hit_3:   rd_mux = charger_event_flags_3_q;
         hit_0:   rd_mux = fault_event_flags_0_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Data holds until the next request so a slow host may take it late;
   // the valid strobe stands for one cycle only
   // Read answer register, valid one cycle after the request
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_en;
         if (rd_en) begin
            rd_data_q <= rd_mux;
         end
      end
   end

   // Interrupt request from the set events
   wire int_req;   // Some unmasked event occurred this cycle

   // The pulse follows the set events, not the flags, so a second event
   // on a flag that is still standing gives a pulse of its own; reserved
   // bits are left out so that a stray mask value cannot matter
   // Only events whose mask bit is zero produce a pulse
   assign int_req = |(set_1 & ~chg_mask_1 & `CHG_FLAGS_1_USED)
                  | |(set_2 & ~chg_mask_2 & `CHG_FLAGS_2_USED)
                  | |(set_3 & ~chg_mask_3 & `CHG_FLAGS_3_USED)
                  | |(set_0 & ~fault_mask_0 & `FAULT_FLAGS_0_USED);             // [R21]

   // Registered so the pin driver sees a clean pulse without glitches
   // One-cycle interrupt pulse per event cycle
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         int_pulse_q <= 1'b0;
      end else begin
         int_pulse_q <= int_req;                                                // [R21]
      end
   end

endmodule // charger_event_flag_bank

`default_nettype wire

// File: verilog/flag_bank_defs.vh
`ifndef FLAG_BANK_DEFS_VH
`define FLAG_BANK_DEFS_VH

// Register offsets on the register read port
`define CHG_FLAGS_1_OFFSET     8'h23
`define CHG_FLAGS_2_OFFSET     8'h24
`define CHG_FLAGS_3_OFFSET     8'h25
`define FAULT_FLAGS_0_OFFSET   8'h26

// Reset value shared by every flag register
`define FLAGS_RESET            8'h00

// Reset value of the settled port detection code
`define PORT_CODE_RESET        4'h0

// Bits that exist in each register; all others read zero
`define CHG_FLAGS_1_USED       8'h01
`define CHG_FLAGS_2_USED       8'h7F
`define CHG_FLAGS_3_USED       8'h1F
`define FAULT_FLAGS_0_USED     8'hFC

// Field positions, first charger flag register
`define PORT_DETECT_CHANGE_BIT 0

// Field positions, second charger flag register
`define DATA_LINE_DONE_BIT     6
`define ADC_DONE_BIT           5
`define MIN_SYSTEM_REG_BIT     4
`define FAST_CHARGE_TMR_BIT    3
`define TRICKLE_TMR_BIT        2
`define PRECHARGE_TMR_BIT      1
`define TOPOFF_TMR_BIT         0

// Field positions, third charger flag register
`define BATT_LOW_OTG_BIT       4
`define THERM_COLD_BIT         3
`define THERM_COOL_BIT         2
`define THERM_WARM_BIT         1
`define THERM_HOT_BIT          0

// Field positions, first fault flag register
`define BATT_CURRENT_REG_BIT   7
`define BUS_OVP_BIT            6
`define BATT_OVP_BIT           5
`define INPUT_OCP_BIT          4
`define BATT_OCP_BIT           3
`define CONV_OCP_BIT           2

// Width of the port detection result code
`define PORT_DETECT_W          4

`endif

// File: verilog/edge_sync.v
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser per bit with edge detection after the second stage
module edge_sync #(
   parameter W = 23
) (
   // Clock and reset
   input  wire         ref_clk,
   input  wire         rst,
   // Asynchronous levels
   input  wire [W-1:0] async_in,
   // Synchronised level and one-cycle edge pulses
   output wire [W-1:0] level,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);

   genvar i;

   // One synchroniser chain per input bit
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta_q;   // First stage, read only by the second
         reg sync_q;   // Second stage, safe to use
         reg prev_q;   // Delayed copy for edge detection

         // Shift the level through the chain
         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
               prev_q <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               sync_q <= meta_q;
               prev_q <= sync_q;
            end
         end

         assign level[i] = sync_q;
         assign rise[i]  = sync_q & ~prev_q;
         assign fall[i]  = ~sync_q & prev_q;
      end
   endgenerate

endmodule // edge_sync

`default_nettype wire

// File: testbench/flag_bank_properties.sv
`timescale 1ns/100ps
`default_nettype none

// Port-level checks on the event flag bank
module flag_bank_properties (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Register read port
   input wire logic       rd_en,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data_q,
   input wire logic       rd_valid_q,
   // Interrupt masks
   input wire logic [7:0] chg_mask_1,
   input wire logic [7:0] chg_mask_2,
   input wire logic [7:0] chg_mask_3,
   input wire logic [7:0] fault_mask_0,
   // Event levels
   input wire logic       data_line_detect_done,
   input wire logic       min_system_reg_active,
   input wire logic [3:0] timer_expired,
   input wire logic [4:0] protection_active,
   // Watched outputs
   input wire logic       int_pulse_q,
   input wire logic [7:0] charger_event_flags_1_q,
   input wire logic [7:0] charger_event_flags_2_q,
   input wire logic [7:0] charger_event_flags_3_q,
   input wire logic [7:0] fault_event_flags_0_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   read_answer_a: assert property (rd_en |=> rd_valid_q)
      else $error("read not answered");
   idle_valid_a: assert property (!rd_en |=> !rd_valid_q)
      else $error("valid without a read");
   data_hold_a: assert property (!rd_en |=> $stable(rd_data_q))
      else $error("read data moved without a read");
   read_data_a: assert property (rd_en && rd_addr == 8'h24
      |=> rd_data_q == $past(charger_event_flags_2_q)) else $error("wrong flag byte");
   unmapped_zero_a: assert property (rd_en && (rd_addr < 8'h23 || rd_addr > 8'h26)
      |=> rd_data_q == 8'h00) else $error("unmapped read not zero");
   reserved_zero_a: assert property ({charger_event_flags_1_q[7:1],
      charger_event_flags_2_q[7], charger_event_flags_3_q[7:5],
      fault_event_flags_0_q[1:0]} == 13'h0000) else $error("reserved bit set");
   timer_rise_a: assert property ($rose(timer_expired[3])
      |-> ##[2:5] charger_event_flags_2_q[3]) else $error("timer flag missed");
   min_sys_exit_a: assert property ($fell(min_system_reg_active)
      |-> ##[2:5] charger_event_flags_2_q[4]) else $error("loop exit missed");
   bus_ovp_a: assert property ($rose(protection_active[4])
      |-> ##[2:5] fault_event_flags_0_q[6]) else $error("bus OVP flag missed");
   line_low_a: assert property (!data_line_detect_done [*5]
      |-> !charger_event_flags_2_q[6]) else $error("done flag while not done");
   masked_pulse_a: assert property ($past((chg_mask_1 & chg_mask_2 & chg_mask_3
      & fault_mask_0) == 8'hFF) |-> !int_pulse_q) else $error("masked pulse");
   unmasked_pulse_a: assert property ($rose(fault_event_flags_0_q[6])
      && !$past(fault_mask_0[6]) |-> int_pulse_q) else $error("pulse missing");
endmodule // flag_bank_properties

bind charger_event_flag_bank flag_bank_properties i_flag_bank_properties (.*);
`default_nettype wire

// File: testbench/host_reader.sv
`timescale 1ns/100ps
`default_nettype none

// Host side of the read port: one byte per request
module host_reader (
   // Clock
   input  wire logic       ref_clk,
   // Read port toward the bank
   output var  logic       rd_en,
   output var  logic [7:0] rd_addr,
   input  wire logic [7:0] rd_data_q,
   input  wire logic       rd_valid_q
);
   // Idle at time zero
   initial begin
      rd_en = 1'b0;
      rd_addr = 8'h00;
   end

   // One read; ok stays low when no answer came
   task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
      @(negedge ref_clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge ref_clk);
      rd_en = 1'b0;
      // A released address no longer shows the last value
      rd_addr = ~a;
      ok = (rd_valid_q === 1'b1);
      d = rd_data_q;
   endtask
endmodule // host_reader
`default_nettype wire

// File: testbench/charger_event_flag_bank_test.sv
`timescale 1ns/100ps
`default_nettype none

// Self-checking bench for the event flag bank
module charger_event_flag_bank_test;
   // Table row: input toggles, register, expected byte
   typedef struct packed {logic [22:0] tog; logic [7:0] addr; logic [7:0] exp;} row_t;

   logic        ref_clk;
   logic        rst;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_data_q;
   logic        rd_valid_q;
   logic [22:0] ev;
   logic [7:0]  cmask;
   logic [7:0]  fmask;
   logic        int_pulse_q;
   logic [7:0]  f1, f2, f3, f0;
   logic [7:0]  d;
   bit          ok;
   int          miscompares, comparisons, i, n;
   row_t rows [0:31] = '{
      '{23'h08_0000, 8'h23, 8'h01}, '{23'h08_0000, 8'h23, 8'h01},
      '{23'h04_0000, 8'h24, 8'h40}, '{23'h04_0000, 8'h24, 8'h00},
      '{23'h02_0000, 8'h24, 8'h00}, '{23'h02_0000, 8'h24, 8'h00},
      '{23'h01_0000, 8'h24, 8'h00}, '{23'h02_0000, 8'h24, 8'h20},
      '{23'h00_8000, 8'h24, 8'h10}, '{23'h00_8000, 8'h24, 8'h10},
      '{23'h00_2000, 8'h24, 8'h08}, '{23'h00_1000, 8'h24, 8'h04},
      '{23'h00_0800, 8'h24, 8'h02}, '{23'h00_0400, 8'h24, 8'h01},
      '{23'h00_3C00, 8'h24, 8'h00}, '{23'h00_0200, 8'h25, 8'h10},
      '{23'h00_0200, 8'h25, 8'h00}, '{23'h00_0100, 8'h25, 8'h08},
      '{23'h00_0080, 8'h25, 8'h04}, '{23'h00_0040, 8'h25, 8'h02},
      '{23'h00_0020, 8'h25, 8'h01}, '{23'h00_01E0, 8'h25, 8'h0F},
      '{23'h00_4000, 8'h26, 8'h80}, '{23'h00_4000, 8'h26, 8'h80},
      '{23'h00_0010, 8'h26, 8'h40}, '{23'h00_0008, 8'h26, 8'h20},
      '{23'h00_0004, 8'h26, 8'h10}, '{23'h00_0002, 8'h26, 8'h08},
      '{23'h00_0001, 8'h26, 8'h04}, '{23'h00_001F, 8'h26, 8'h00},
      '{23'h00_0000, 8'h27, 8'h00}, '{23'h00_0010, 8'h22, 8'h00}};

   charger_event_flag_bank i_charger_event_flag_bank (
      .ref_clk(ref_clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .chg_mask_1(cmask),
      .chg_mask_2(cmask), .chg_mask_3(cmask), .fault_mask_0(fmask),
      .port_detect_result(ev[22:19]), .data_line_detect_done(ev[18]),
      .adc_conv_done(ev[17]), .adc_one_shot(ev[16]), .min_system_reg_active(ev[15]),
      .battery_current_reg_active(ev[14]), .timer_expired(ev[13:10]),
      .battery_low_for_otg(ev[9]), .thermistor_zone(ev[8:5]),
      .protection_active(ev[4:0]), .int_pulse_q(int_pulse_q),
      .charger_event_flags_1_q(f1), .charger_event_flags_2_q(f2),
      .charger_event_flags_3_q(f3), .fault_event_flags_0_q(f0));

   host_reader i_host_reader (.ref_clk(ref_clk), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Verdict and end of run
   task report_and_stop;
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Compare one byte and count it
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read one register; a missing answer ends the run
   task rd(input logic [7:0] a);
      i_host_reader.read(a, d, ok);
      chk({7'h00, ok}, 8'h01);
      if (!ok)
         report_and_stop();
   endtask

   // Toggle inputs, then let six cycles pass counting pulses
   task step(input logic [22:0] t);
      @(negedge ref_clk);
      ev = ev ^ t;
      n = 0;
      repeat (6) begin
         @(negedge ref_clk);
         if (int_pulse_q === 1'b1)
            n++;
      end
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      ev = '0;
      cmask = 8'h00;
      fmask = 8'h00;
      miscompares = 0;
      comparisons = 0;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      // Every flag register reads zero after power-on
      for (i = 0; i < 4; i++) begin
         rd(8'h23 + i[7:0]);
         chk(d, 8'h00);
      end
      // Table: event, read, then a second read returns zero; the two unmapped rows clear nothing
      for (i = 0; i < 32; i++) begin
         step(rows[i].tog);
         rd(rows[i].addr);
         chk(d, rows[i].exp);
         rd(rows[i].addr);
         chk(d, 8'h00);
      end
      // Unmapped reads left the bus over-voltage flag standing
      rd(8'h26);
      chk(d, 8'h40);
      // Masked event sets its flag without a pulse
      cmask = 8'hFF;
      fmask = 8'hFF;
      step(23'h00_0008);
      chk(n[7:0], 8'h00);
      rd(8'h26);
      chk(d, 8'h20);
      step(23'h00_0008);
      fmask = 8'hDF;
      step(23'h00_0008);
      chk(n[7:0], 8'h01);
      rd(8'h26);
      chk(d, 8'h20);
      // Reset in mid-run clears every flag at once
      step(23'h00_0004);
      chk(f0, 8'h10);
      rst = 1'b1;
      @(negedge ref_clk);
      chk(f0 | f1 | f2 | f3 | {7'h00, int_pulse_q}, 8'h00);
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      // Levels still standing at release are seen as fresh events
      repeat (6) @(negedge ref_clk);
      rd(8'h26);
      chk(d, 8'h70);
      rd(8'h24);
      chk(d, 8'h20);
      report_and_stop();
   end
endmodule // charger_event_flag_bank_test
`default_nettype wire
